// ---- common/mcu_timing_consts.svh ----
// Constants for the instruction cycle timing core
`ifndef MCU_TIMING_CONSTS_SVH
`define MCU_TIMING_CONSTS_SVH
`define CLK_PERIOD_NS      50
`define CLOCKS_PER_CYCLE   4
`define PHASE_LAST         2'h3
`define PC_WIDTH           12
`define PC_RESET           12'h000
`define STACK_DEPTH        8
`define DATA_ADDR_WIDTH    7
`define OP_WIDTH           5
`define INSTR_WIDTH        16
`define PCL_ADDR           7'h02
`define OSC_FAST_RC_SLOW_RC  2'h0
`define OSC_FAST_RC_WATCH    2'h1
`define OSC_FAST_XTAL_SLOW_RC 2'h2
`endif

// ---- common/mcu_timing_pkg.sv ----
// Types for the instruction cycle timing core
package mcu_timing_pkg;
   typedef enum logic [4:0] {
      OP_NOP       = 5'h00,
      OP_MOV_AM    = 5'h01,
      OP_MOV_MA    = 5'h02,
      OP_MOV_AX    = 5'h03,
      OP_ADD       = 5'h04,
      OP_SUB       = 5'h05,
      OP_AND       = 5'h06,
      OP_OR        = 5'h07,
      OP_XOR       = 5'h08,
      OP_COMPL     = 5'h09,
      OP_INC       = 5'h0A,
      OP_SUBONE    = 5'h0B,
      OP_ROTR      = 5'h0C,
      OP_ROTL      = 5'h0D,
      OP_ROTRC     = 5'h0E,
      OP_ROTLC     = 5'h0F,
      OP_BITSET    = 5'h10,
      OP_BITCLR    = 5'h11,
      OP_JUMP      = 5'h12,
      OP_CALL      = 5'h13,
      OP_SUBEXIT   = 5'h14,
      OP_INTEXIT   = 5'h15,
      OP_SKIPZ     = 5'h16,
      OP_SKIPNZ    = 5'h17,
      OP_SKIPBZ    = 5'h18,
      OP_SKIPBNZ   = 5'h19,
      OP_TABREAD   = 5'h1A,
      OP_POWERDOWN = 5'h1B,
      OP_WDTCLR    = 5'h1C
   } op_t;
   typedef enum logic [1:0] {
      ST_FETCH  = 2'b00,
      ST_EXEC   = 2'b01,
      ST_FLUSH  = 2'b10,
      ST_DOWN   = 2'b11
   } state_t;
endpackage : mcu_timing_pkg

// ---- src/mcu_instruction_cycle_timing.sv ----
// Instruction cycle sequencer and datapath of the 8-bit core
`timescale 1ns/1ns
`include "mcu_timing_consts.svh"
// Function
// - One instruction cycle is four system clocks; everything steps per cycle.
// - Ordinary instructions take one cycle; branch, call, table read take two.
// - Jump, call, subroutine exit and interrupt exit add one cycle.
// - Writing the program counter low byte jumps there and adds one cycle.
// - Skip takes one cycle when not taken, one more when taken.
// - Skips test a byte or bit and bypass the next instruction.
// - Subroutine exit resumes after the call; a jump saves no return point.
// - Logical operations set zero flag when result is zero.
// - Add reports carry above 255; subtract reports borrow below zero.
// - Increment and decrement change destination by exactly one.
// - Rotates shift one bit; through-carry forms move outgoing bit to carry.
// - Bit set and clear change only the addressed bit.
// - Table read fetches program memory data and returns it to data side.
// - Power-down instruction stops the core; watchdog clear has its own instruction.
// - Direct data addressing reaches sector 0 only.
// - Oscillator pairing is fixed at programming time, not by program.
module mcu_instruction_cycle_timing #(
   parameter logic [1:0] OSC_PAIRING = `OSC_FAST_RC_SLOW_RC
) (
   input  wire logic                        clk_sys,
   input  wire logic                        reset,
   output logic [`PC_WIDTH-1:0]             progAddr,
   input  wire logic [`INSTR_WIDTH-1:0]     progData,
   input  wire logic                        wakeUp,
   output logic [1:0]                       oscPairing,
   output logic                             powerDown,
   output logic                             watchdogClear,
   output logic                             cycleStart,
   output logic [7:0]                       accOut,
   output logic                             zeroFlag,
   output logic                             carryFlag
);
   // Instruction word: [15:11] op, [10:8] bit index, [7:0] pcl target, [6:0] addr/imm
   localparam logic [`DATA_ADDR_WIDTH-1:0] PCL_ADDR = `PCL_ADDR;

   mcu_timing_pkg::state_t state_q;
   logic [1:0]                 phase_q;
   logic [`PC_WIDTH-1:0]       pc_q;
   logic [`INSTR_WIDTH-1:0]    ir_q;
   logic [7:0]                 acc_q;
   logic                       z_q;
   logic                       c_q;
   logic [7:0]                 ram_q [0:(1<<`DATA_ADDR_WIDTH)-1];
   logic [`PC_WIDTH-1:0]       stack_q [0:`STACK_DEPTH-1];
   logic [2:0]                 sp_q;
   logic                       pd_q;
   logic                       wdt_q;
   logic                       wake1_q;
   logic                       wake2_q;
   logic [1:0]                 osc_q;
   logic [`PC_WIDTH-1:0]       tabPtr_q;

   wire logic                  cycleEnd  = (phase_q == `PHASE_LAST);
   wire mcu_timing_pkg::op_t   op        = mcu_timing_pkg::op_t'(ir_q[15:11]);
   wire logic [2:0]            bitIdx    = ir_q[10:8];
   // Direct addressing only reaches sector 0; the 7-bit field cannot name more
   wire logic [`DATA_ADDR_WIDTH-1:0] addr = ir_q[6:0];
   wire logic [7:0]            mem       = ram_q[addr];
   wire logic [7:0]            imm       = {1'b0, ir_q[6:0]};
   wire logic [8:0]            addSum    = {1'b0, acc_q} + {1'b0, mem};
   wire logic [8:0]            subDiff   = {1'b0, acc_q} - {1'b0, mem};
   wire logic [7:0]            bitMask   = 8'h01 << bitIdx;
   wire logic                  memZero   = (mem == 8'h00);
   wire logic                  bitZero   = ((mem & bitMask) == 8'h00);
   wire logic                  skipTaken = (op == mcu_timing_pkg::OP_SKIPZ   &&  memZero) ||
                                           (op == mcu_timing_pkg::OP_SKIPNZ  && !memZero) ||
                                           (op == mcu_timing_pkg::OP_SKIPBZ  &&  bitZero) ||
                                           (op == mcu_timing_pkg::OP_SKIPBNZ && !bitZero);
   wire logic                  memWrite  = (op == mcu_timing_pkg::OP_MOV_MA) ||
                                           (op == mcu_timing_pkg::OP_INC)   ||
                                           (op == mcu_timing_pkg::OP_SUBONE) ||
                                           (op == mcu_timing_pkg::OP_COMPL) ||
                                           (op == mcu_timing_pkg::OP_ROTR)  ||
                                           (op == mcu_timing_pkg::OP_ROTL)  ||
                                           (op == mcu_timing_pkg::OP_ROTRC) ||
                                           (op == mcu_timing_pkg::OP_ROTLC) ||
                                           (op == mcu_timing_pkg::OP_BITSET) ||
                                           (op == mcu_timing_pkg::OP_BITCLR);
   wire logic                  pclWrite  = memWrite && (addr == PCL_ADDR);
   wire logic                  isBranch  = (op == mcu_timing_pkg::OP_JUMP)    ||
                                           (op == mcu_timing_pkg::OP_CALL)    ||
                                           (op == mcu_timing_pkg::OP_SUBEXIT) ||
                                           (op == mcu_timing_pkg::OP_INTEXIT);
   wire logic                  twoCycle  = isBranch || pclWrite || skipTaken ||
                                           (op == mcu_timing_pkg::OP_TABREAD);
   wire logic                  wakeSync  = wake2_q;

   // Result of the data-side operation and its flag effects
   logic [7:0] result;
   logic       newZ;
   logic       newC;
   always_comb begin
      result = mem;
      newZ   = z_q;
      newC   = c_q;
      case (op)
         mcu_timing_pkg::OP_ADD: begin
            result = addSum[7:0];
            newC   = addSum[8];
            newZ   = (addSum[7:0] == 8'h00);
         end
         mcu_timing_pkg::OP_SUB: begin
            result = subDiff[7:0];
            // Carry set means no borrow, so a chained subtract can test it directly
            newC   = ~subDiff[8];
            newZ   = (subDiff[7:0] == 8'h00);
         end
         mcu_timing_pkg::OP_AND: begin
            result = acc_q & mem;
            newZ   = (result == 8'h00);
         end
         mcu_timing_pkg::OP_OR: begin
            result = acc_q | mem;
            newZ   = (result == 8'h00);
         end
         mcu_timing_pkg::OP_XOR: begin
            result = acc_q ^ mem;
            newZ   = (result == 8'h00);
         end
         mcu_timing_pkg::OP_COMPL: begin
            result = ~mem;
            newZ   = (result == 8'h00);
         end
         mcu_timing_pkg::OP_INC: begin
            result = mem + 8'h01;
            newZ   = (result == 8'h00);
         end
         mcu_timing_pkg::OP_SUBONE: begin
            result = mem - 8'h01;
            newZ   = (result == 8'h00);
         end
         mcu_timing_pkg::OP_ROTR:   result = {mem[0], mem[7:1]};
         mcu_timing_pkg::OP_ROTL:   result = {mem[6:0], mem[7]};
         mcu_timing_pkg::OP_ROTRC: begin
            result = {c_q, mem[7:1]};
            newC   = mem[0];
         end
         mcu_timing_pkg::OP_ROTLC: begin
            result = {mem[6:0], c_q};
            newC   = mem[7];
         end
         mcu_timing_pkg::OP_BITSET: result = mem | bitMask;
         mcu_timing_pkg::OP_BITCLR: result = mem & ~bitMask;
         mcu_timing_pkg::OP_MOV_MA: result = acc_q;
         default:                   result = mem;
      endcase
   end

   // Next program counter at the end of an execute cycle
   logic [`PC_WIDTH-1:0] pcNext;
   always_comb begin
      pcNext = pc_q + `PC_WIDTH'(1);
      case (op)
         mcu_timing_pkg::OP_JUMP, mcu_timing_pkg::OP_CALL:
            pcNext = {pc_q[`PC_WIDTH-1:8], ir_q[7:0]};
         mcu_timing_pkg::OP_SUBEXIT, mcu_timing_pkg::OP_INTEXIT:
            pcNext = stack_q[sp_q - 3'h1];
         default: begin
            if (pclWrite) begin
               pcNext = {pc_q[`PC_WIDTH-1:8], result};
            end else if (skipTaken) begin
               pcNext = pc_q + `PC_WIDTH'(2);
            end
         end
      endcase
   end

   // Phase counter divides the system clock into instruction cycles
   always_ff @(posedge clk_sys) begin
      if (reset || state_q == mcu_timing_pkg::ST_DOWN) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wake1_q <= 1'b0;
         wake2_q <= 1'b0;
      end else begin
         wake1_q <= wakeUp;
         wake2_q <= wake1_q;
      end
   end

   // Pairing is a build-time constant; no instruction has a path to it
   always_ff @(posedge clk_sys) begin
      osc_q <= OSC_PAIRING;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q  <= mcu_timing_pkg::ST_FETCH;
         pc_q     <= `PC_RESET;
         ir_q     <= '0;
         acc_q    <= 8'h00;
         z_q      <= 1'b0;
         c_q      <= 1'b0;
         sp_q     <= 3'h0;
         pd_q     <= 1'b0;
         wdt_q    <= 1'b0;
         tabPtr_q <= '0;
      end else begin
         wdt_q <= 1'b0;
         case (state_q)
            mcu_timing_pkg::ST_FETCH: begin
               if (cycleEnd) begin
                  ir_q    <= progData;
                  state_q <= mcu_timing_pkg::ST_EXEC;
               end
            end
            mcu_timing_pkg::ST_EXEC: begin
               if (cycleEnd) begin
                  pc_q <= pcNext;
                  z_q  <= newZ;
                  c_q  <= newC;
                  ir_q <= progData;
                  case (op)
                     mcu_timing_pkg::OP_MOV_AM: acc_q <= mem;
                     mcu_timing_pkg::OP_MOV_AX: acc_q <= imm;
                     mcu_timing_pkg::OP_ADD, mcu_timing_pkg::OP_SUB, mcu_timing_pkg::OP_AND,
                     mcu_timing_pkg::OP_OR, mcu_timing_pkg::OP_XOR: acc_q <= result;
                     mcu_timing_pkg::OP_TABREAD: acc_q <= progData[7:0];
                     mcu_timing_pkg::OP_CALL: sp_q <= sp_q + 3'h1;
                     mcu_timing_pkg::OP_SUBEXIT, mcu_timing_pkg::OP_INTEXIT: sp_q <= sp_q - 3'h1;
                     mcu_timing_pkg::OP_POWERDOWN: pd_q <= 1'b1;
                     mcu_timing_pkg::OP_WDTCLR: wdt_q <= 1'b1;
                     default: acc_q <= acc_q;
                  endcase
                  if (op == mcu_timing_pkg::OP_TABREAD) begin
                     tabPtr_q <= tabPtr_q + `PC_WIDTH'(1);
                  end
                  if (op == mcu_timing_pkg::OP_POWERDOWN) begin
                     state_q <= mcu_timing_pkg::ST_DOWN;
                  end else if (twoCycle) begin
                     state_q <= mcu_timing_pkg::ST_FLUSH;
                  end
               end
            end
            mcu_timing_pkg::ST_FLUSH: begin
               // Prefetched word is dropped; fetch from the new counter
               if (cycleEnd) begin
                  state_q <= mcu_timing_pkg::ST_EXEC;
                  ir_q    <= progData;
               end
            end
            mcu_timing_pkg::ST_DOWN: begin
               if (wakeSync) begin
                  pd_q    <= 1'b0;
                  state_q <= mcu_timing_pkg::ST_FETCH;
               end
            end
            default: state_q <= mcu_timing_pkg::ST_FETCH;
         endcase
      end
   end

   // Call pushes the address after itself; a jump touches no stack
   always_ff @(posedge clk_sys) begin
      if (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && op == mcu_timing_pkg::OP_CALL) begin
         stack_q[sp_q] <= pc_q + `PC_WIDTH'(1);
      end
   end

   // Whole byte rewritten, other bits carried from the read
   always_ff @(posedge clk_sys) begin
      if (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && memWrite) begin
         ram_q[addr] <= result;
      end
   end

   // Execute shows the next word so it is prefetched while this one runs;
   // a table read borrows the port for its pointer instead
   wire logic [`PC_WIDTH-1:0]  pcPlusOne = pc_q + `PC_WIDTH'(1);
   assign progAddr = (state_q != mcu_timing_pkg::ST_EXEC) ? pc_q :
                     (op == mcu_timing_pkg::OP_TABREAD) ? tabPtr_q : pcPlusOne;
   assign oscPairing    = osc_q;
   assign powerDown     = pd_q;
   assign watchdogClear = wdt_q;
   assign cycleStart    = (phase_q == 2'h0) && (state_q != mcu_timing_pkg::ST_DOWN);
   assign accOut        = acc_q;
   assign zeroFlag      = z_q;
   assign carryFlag     = c_q;

   property p_cycle_len;
      @(posedge clk_sys) disable iff (reset)
      cycleStart |-> ##4 (cycleStart || powerDown);
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("instruction cycle not four clocks");
   property p_flush_len;
      @(posedge clk_sys) disable iff (reset)
      $rose(state_q == mcu_timing_pkg::ST_FLUSH) |->
      (state_q == mcu_timing_pkg::ST_FLUSH)[*4];
   endproperty
   a_flush_len: assert property (p_flush_len)
      else $error("flush cycle not four clocks");
   property p_jump_two;
      @(posedge clk_sys) disable iff (reset)
      (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && isBranch) |=>
      state_q == mcu_timing_pkg::ST_FLUSH;
   endproperty
   a_jump_two: assert property (p_jump_two)
      else $error("branch did not take extra cycle");
   property p_pcl_two;
      @(posedge clk_sys) disable iff (reset)
      (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && pclWrite) |=>
      state_q == mcu_timing_pkg::ST_FLUSH && pc_q[7:0] == $past(result);
   endproperty
   a_pcl_two: assert property (p_pcl_two)
      else $error("counter low write not a jump");
   property p_noskip_one;
      @(posedge clk_sys) disable iff (reset)
      (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && !twoCycle &&
       op != mcu_timing_pkg::OP_POWERDOWN)
      |=> state_q == mcu_timing_pkg::ST_EXEC && pc_q == $past(pc_q) + `PC_WIDTH'(1);
   endproperty
   a_noskip_one: assert property (p_noskip_one)
      else $error("single cycle instruction mistimed");
   property p_skip_pc;
      @(posedge clk_sys) disable iff (reset)
      (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && skipTaken) |=>
      pc_q == $past(pc_q) + `PC_WIDTH'(2);
   endproperty
   a_skip_pc: assert property (p_skip_pc)
      else $error("skip did not bypass next");
   property p_zero_logic;
      @(posedge clk_sys) disable iff (reset)
      (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && op == mcu_timing_pkg::OP_AND) |=>
      zeroFlag == (accOut == 8'h00);
   endproperty
   a_zero_logic: assert property (p_zero_logic)
      else $error("zero flag wrong after logic op");
   property p_osc_fixed;
      @(posedge clk_sys) disable iff (reset)
      ##1 $stable(oscPairing);
   endproperty
   a_osc_fixed: assert property (p_osc_fixed)
      else $error("oscillator pairing changed");
   property p_down_stop;
      @(posedge clk_sys) disable iff (reset)
      (state_q == mcu_timing_pkg::ST_EXEC && cycleEnd && op == mcu_timing_pkg::OP_POWERDOWN)
      |=> powerDown ##1 (powerDown || wakeSync);
   endproperty
   a_down_stop: assert property (p_down_stop)
      else $error("power down not entered");
endmodule : mcu_instruction_cycle_timing

// ---- testbench/prog_mem_model.sv ----
// Program memory model on the far side of the core's fetch port
`timescale 1ns/1ns
`include "mcu_timing_consts.svh"
module prog_mem_model (
   input  wire logic [`PC_WIDTH-1:0]    progAddr,
   output logic      [`INSTR_WIDTH-1:0] progData
);
   // Loaded by the bench only while the core is stopped or held in reset
   logic [`INSTR_WIDTH-1:0] mem [0:(1<<`PC_WIDTH)-1];
   // Same-clock read, so a word is valid in the cycle its address is shown
   assign progData = mem[progAddr];
endmodule : prog_mem_model

// ---- testbench/tb.sv ----
// Self-checking bench for the instruction cycle timing core
`timescale 1ns/1ns
`include "mcu_timing_consts.svh"
module tb;
   logic                    clk_sys = 1'b0;
   logic                    reset   = 1'b1;
   logic                    wakeUp  = 1'b0;
   logic [`PC_WIDTH-1:0]    progAddr;
   logic [`INSTR_WIDTH-1:0] progData;
   logic [1:0]              oscPairing;
   logic                    powerDown;
   logic                    watchdogClear;
   logic                    cycleStart;
   logic [7:0]              accOut;
   logic                    zeroFlag;
   logic                    carryFlag;
   int                      error_cnt = 0;
   int                      cmp_count = 0;
   int                      wp;
   int                      base;
   int                      wdCnt;

   always #(`CLK_PERIOD_NS/2) clk_sys = ~clk_sys;

   // A pairing other than the default shows the option really reaches the core
   mcu_instruction_cycle_timing #(.OSC_PAIRING(`OSC_FAST_XTAL_SLOW_RC)) DUT (
      .clk_sys(clk_sys), .reset(reset), .progAddr(progAddr), .progData(progData),
      .wakeUp(wakeUp), .oscPairing(oscPairing), .powerDown(powerDown),
      .watchdogClear(watchdogClear), .cycleStart(cycleStart), .accOut(accOut),
      .zeroFlag(zeroFlag), .carryFlag(carryFlag));
   prog_mem_model progMem (.progAddr(progAddr), .progData(progData));

   task automatic results();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask : check

   task automatic clear();
      for (int i = 0; i < (1 << `PC_WIDTH); i++) begin
         progMem.mem[i] = {mcu_timing_pkg::OP_POWERDOWN, 11'h000};
      end
      wp = 0;
   endtask : clear

   task automatic emit(input mcu_timing_pkg::op_t op, input logic [2:0] b, input logic [7:0] arg);
      progMem.mem[wp] = {op, b, arg};
      wp++;
   endtask : emit

   // Counts instruction cycles from reset release to power-down; the overhead of
   // fetch and the stop itself is measured once so only per-instruction cost is judged
   task automatic run(input int extra, input logic [7:0] accExp, input logic zExp,
                      input logic cExp);
      int n;
      n = 0;
      wdCnt = 0;
      reset = 1'b1;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      for (int i = 0; i < 300 && powerDown !== 1'b1; i++) begin
         @(negedge clk_sys);
         if (cycleStart === 1'b1 && powerDown !== 1'b1) n++;
         if (watchdogClear === 1'b1) wdCnt++;
      end
      if (powerDown !== 1'b1) begin
         error_cnt++;
         results();
      end else begin
         if (extra < 0) base = n;
         else check(16'(n), 16'(base + extra));
         check({8'h00, accOut}, {8'h00, accExp});
         check({14'h0000, zeroFlag, carryFlag}, {14'h0000, zExp, cExp});
      end
   endtask : run

   task automatic waitDown(input logic lvl, input int lim);
      for (int i = 0; i < lim && powerDown !== lvl; i++) @(negedge clk_sys);
      if (powerDown !== lvl) begin
         error_cnt++;
         results();
      end
   endtask : waitDown

   task automatic sBase();
      clear();
      repeat (2) @(negedge clk_sys);
      check({progAddr, accOut[3:0]}, 16'h0000);
      check({13'h0000, powerDown, zeroFlag, carryFlag}, 16'h0000);
      check({14'h0000, oscPairing}, {14'h0000, `OSC_FAST_XTAL_SLOW_RC});
      run(-1, 8'h00, 1'b0, 1'b0);
   endtask : sBase

   task automatic sArith();
      clear();
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h2A);
      emit(mcu_timing_pkg::OP_MOV_MA, 3'h0, 8'h10);
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h55);
      emit(mcu_timing_pkg::OP_AND, 3'h0, 8'h10);
      run(4, 8'h00, 1'b1, 1'b0);
      clear();
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h7F);
      emit(mcu_timing_pkg::OP_MOV_MA, 3'h0, 8'h10);
      emit(mcu_timing_pkg::OP_ADD, 3'h0, 8'h10);
      emit(mcu_timing_pkg::OP_ADD, 3'h0, 8'h10);
      run(4, 8'h7D, 1'b0, 1'b1);
      wp = 2;
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h01);
      emit(mcu_timing_pkg::OP_SUB, 3'h0, 8'h10);
      run(4, 8'h82, 1'b0, 1'b0);
      wp = 2;
      emit(mcu_timing_pkg::OP_SUB, 3'h0, 8'h10);
      emit(mcu_timing_pkg::OP_POWERDOWN, 3'h0, 8'h00);
      run(3, 8'h00, 1'b1, 1'b1);
   endtask : sArith

   // The result is folded back with the source byte, so it holds whether the
   // operation lands in the accumulator or in data memory
   task automatic sModify();
      mcu_timing_pkg::op_t ops [9] = '{mcu_timing_pkg::OP_INC, mcu_timing_pkg::OP_SUBONE,
         mcu_timing_pkg::OP_ROTR, mcu_timing_pkg::OP_ROTL, mcu_timing_pkg::OP_ROTRC,
         mcu_timing_pkg::OP_ROTLC, mcu_timing_pkg::OP_BITSET, mcu_timing_pkg::OP_BITCLR,
         mcu_timing_pkg::OP_COMPL};
      logic [2:0] bits [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h2, 3'h0};
      logic [7:0] res [9] = '{8'h03, 8'h01, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h08, 8'h04, 8'hFF};
      logic cy [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      for (int k = 0; k < 9; k++) begin
         clear();
         emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h55);
         emit(mcu_timing_pkg::OP_MOV_MA, 3'h0, 8'h10);
         emit(ops[k], bits[k], 8'h10);
         emit(mcu_timing_pkg::OP_XOR, 3'h0, 8'h10);
         run(4, res[k], 1'b0, cy[k]);
      end
   endtask : sModify

   task automatic sBranch();
      mcu_timing_pkg::op_t exits [2] = '{mcu_timing_pkg::OP_SUBEXIT, mcu_timing_pkg::OP_INTEXIT};
      clear();
      emit(mcu_timing_pkg::OP_JUMP, 3'h0, 8'h05);
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h11);
      wp = 5;
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h22);
      run(3, 8'h22, 1'b0, 1'b0);
      for (int k = 0; k < 2; k++) begin
         clear();
         emit(mcu_timing_pkg::OP_CALL, 3'h0, 8'h08);
         emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h33);
         wp = 8;
         emit(exits[k], 3'h0, 8'h00);
         run(5, 8'h33, 1'b0, 1'b0);
      end
      clear();
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h06);
      emit(mcu_timing_pkg::OP_MOV_MA, 3'h0, 8'h02);
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h11);
      wp = 6;
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h22);
      run(4, 8'h22, 1'b0, 1'b0);
   endtask : sBranch

   task automatic sSkip();
      mcu_timing_pkg::op_t ops [6] = '{mcu_timing_pkg::OP_SKIPZ, mcu_timing_pkg::OP_SKIPZ,
         mcu_timing_pkg::OP_SKIPNZ, mcu_timing_pkg::OP_SKIPBZ, mcu_timing_pkg::OP_SKIPBNZ,
         mcu_timing_pkg::OP_SKIPBZ};
      logic [7:0] val [6] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
      logic [2:0] bits [6] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0};
      logic [7:0] res [6] = '{8'h00, 8'h66, 8'h04, 8'h66, 8'h04, 8'h04};
      for (int k = 0; k < 6; k++) begin
         clear();
         emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, val[k]);
         emit(mcu_timing_pkg::OP_MOV_MA, 3'h0, 8'h10);
         emit(ops[k], bits[k], 8'h10);
         emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h66);
         run(4, res[k], 1'b0, 1'b0);
      end
   endtask : sSkip

   // Each table word has equal high and low bytes, so either byte lane reads alike
   task automatic sTable();
      clear();
      emit(mcu_timing_pkg::OP_TABREAD, 3'h2, 8'hD2);
      emit(mcu_timing_pkg::OP_TABREAD, 3'h5, 8'hD5);
      run(4, 8'hD5, 1'b0, 1'b0);
   endtask : sTable

   task automatic sSleep();
      logic [`PC_WIDTH-1:0] held;
      clear();
      emit(mcu_timing_pkg::OP_WDTCLR, 3'h0, 8'h00);
      emit(mcu_timing_pkg::OP_POWERDOWN, 3'h0, 8'h00);
      emit(mcu_timing_pkg::OP_MOV_AX, 3'h0, 8'h77);
      run(1, 8'h00, 1'b0, 1'b0);
      check(16'(wdCnt), 16'h0001);
      held = progAddr;
      repeat (8) @(negedge clk_sys);
      check({3'h0, powerDown, progAddr}, {4'h1, held});
      wakeUp = 1'b1;
      waitDown(1'b0, 20);
      wakeUp = 1'b0;
      waitDown(1'b1, 50);
      check({8'h00, accOut}, 16'h0077);
      check({14'h0000, oscPairing}, {14'h0000, `OSC_FAST_XTAL_SLOW_RC});
   endtask : sSleep

   initial begin
      sBase();
      sArith();
      sModify();
      sBranch();
      sSkip();
      sTable();
      sSleep();
      results();
   end
endmodule : tb
